// file: hdl/cprc_axil.sv
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes the register file decodes rd_addr combinationally.
`timescale 1ns/1ps
module cprc_axil
  import cprc_pkg::*;
#(
  parameter int AW = 8
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  output logic [1:0]         s_axi_bresp,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  input  wire logic [AW-1:0] s_axi_araddr,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               wr_en,
  output logic [AW-1:0]      wr_addr,
  output logic [31:0]        wr_data,
  output logic [3:0]         wr_strb,
  input  wire logic          wr_hit,
  output logic [AW-1:0]      rd_addr,
  input  wire logic [31:0]   rd_data,
  input  wire logic          rd_hit
);
  typedef struct packed {
    logic          aw_v;
    logic [AW-1:0] aw_a;
    logic          w_v;
    logic [31:0]   w_d;
    logic [3:0]    w_s;
    logic          b_v;
    logic          b_err;
    logic          r_v;
    logic [31:0]   r_d;
    logic          r_err;
  } cprc_axil_st_t;
  cprc_axil_st_t q, d;

  // Address and data are held until both are present; the write then
  // lands in one cycle and the response follows on the next edge.
  always_comb begin
    d = q;
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_v = 1'b1;
      d.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_v = 1'b1;
      d.w_d = s_axi_wdata;
      d.w_s = s_axi_wstrb;
    end
    if (wr_en) begin
      d.aw_v  = 1'b0;
      d.w_v   = 1'b0;
      d.b_v   = 1'b1;
      d.b_err = !wr_hit;
    end
    if (q.b_v && s_axi_bready) begin
      d.b_v = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.r_v   = 1'b1;
      d.r_d   = rd_hit ? rd_data : 32'h0000_0000;
      d.r_err = !rd_hit;
    end else if (q.r_v && s_axi_rready) begin
      d.r_v = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Handshakes are combinational; payloads come from flops except rd_addr, taken straight from s_axi_araddr.
  assign s_axi_awready = !q.aw_v && !q.b_v;
  assign s_axi_wready  = !q.w_v && !q.b_v;
  assign s_axi_bvalid  = q.b_v;
  assign s_axi_bresp   = q.b_err ? CPRC_SLVERR : CPRC_OKAY;
  assign s_axi_arready = !q.r_v;
  assign s_axi_rvalid  = q.r_v;
  assign s_axi_rdata   = q.r_d;
  assign s_axi_rresp   = q.r_err ? CPRC_SLVERR : CPRC_OKAY;
  assign wr_en         = q.aw_v && q.w_v && !q.b_v;
  assign wr_addr       = q.aw_a;
  assign wr_data       = q.w_d;
  assign wr_strb       = q.w_s;
  assign rd_addr       = s_axi_araddr;
endmodule : cprc_axil

// file: hdl/cprc_div.sv
// Programmable divider of an enable pulse train.
// Assumes tick_in is a one-cycle enable in the aclk domain.
`timescale 1ns/1ps
module cprc_div #(
  parameter int W = 4
) (
  input  wire logic         aclk,
  input  wire logic         rst_n,
  input  wire logic         tick_in,
  input  wire logic         en,
  input  wire logic [W-1:0] div,
  output logic              tick_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] div_a;
    logic         en_a;
    logic         tick;
  } cprc_div_st_t;
  cprc_div_st_t q, d;

  // Output rate is tick_in over div+1. While enabled, new settings load only
  // at the end of a whole period, so no shortened period ever appears.
  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (!q.en_a) begin
      d.div_a = div;
      d.en_a  = en;
      d.cnt   = '0;
    end else if (tick_in) begin
      if (q.cnt >= q.div_a) begin
        d.cnt   = '0;
        d.tick  = 1'b1;
        d.div_a = div;
        d.en_a  = en;
      end else begin
        d.cnt = q.cnt + 1'b1;
      end
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_out = q.tick;
endmodule : cprc_div

// file: hdl/cprc_pkg.sv
// Constants shared by the clock, power and reset controller.
// Assumes one 100 MHz aclk; every derived clock is an enable pulse.
package cprc_pkg;
  // Register byte offsets.
  localparam logic [7:0] CPRC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] CPRC_PLL_OFS    = 8'h04;
  localparam logic [7:0] CPRC_CPU_OFS    = 8'h08;
  localparam logic [7:0] CPRC_GPF_OFS    = 8'h0c;
  localparam logic [7:0] CPRC_GPS_OFS    = 8'h10;
  localparam logic [7:0] CPRC_I2S_OFS    = 8'h14;
  localparam logic [7:0] CPRC_MODE_OFS   = 8'h18;
  localparam logic [7:0] CPRC_WKEN_OFS   = 8'h1c;
  localparam logic [7:0] CPRC_WKEV_OFS   = 8'h20;
  localparam logic [7:0] CPRC_STAT_OFS   = 8'h24;
  // Control bits; the two reset bits are self-clearing.
  localparam int CPRC_CPU_RST_B = 0;
  localparam int CPRC_DEV_RST_B = 1;
  localparam int CPRC_WARM_B    = 2;
  localparam int CPRC_FREEZE_B  = 3;
  localparam int CPRC_LPINT_B   = 4;
  localparam int CPRC_PLL_EN_B  = 0;
  localparam int CPRC_SB_REF_B  = 1;
  // Processor clock configuration fields.
  localparam int CPRC_SEL_LSB   = 0;
  localparam int CPRC_CDIV_LSB  = 2;
  localparam int CPRC_DDIV_LSB  = 6;
  localparam int CPRC_MDIV_LSB  = 10;
  localparam int CPRC_DMA_ON_B  = 14;
  localparam int CPRC_MMIO_ON_B = 15;
  // Peripheral clock fields and the wakeup level polarity bit.
  localparam int CPRC_PDIV_LSB  = 2;
  localparam int CPRC_PEN_B     = 15;
  localparam int CPRC_EXT_B     = 16;
  localparam int CPRC_WK_POL_B  = 8;
  // Wakeup source positions.
  localparam int CPRC_WK_LEVEL  = 0;
  localparam int CPRC_WK_EDGE   = 1;
  localparam int CPRC_WK_N      = 7;
  // Reset values and writable masks.
  localparam logic [31:0] CPRC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CPRC_PLL_RST  = 32'h0000_0001;
  localparam logic [31:0] CPRC_CPU_RST  = 32'h0000_c444;
  localparam logic [31:0] CPRC_PER_RST  = 32'h0000_0000;
  localparam logic [31:0] CPRC_WK_RST   = 32'h0000_0000;
  localparam logic [31:0] CPRC_CTRL_WM  = 32'h0000_001c;
  localparam logic [31:0] CPRC_PLL_WM   = 32'h0000_0003;
  localparam logic [31:0] CPRC_CPU_WM   = 32'h0000_ffff;
  localparam logic [31:0] CPRC_PER_WM   = 32'h0000_83ff;
  localparam logic [31:0] CPRC_I2S_WM   = 32'h0001_83ff;
  localparam logic [31:0] CPRC_WK_WM    = 32'h0000_017f;
  // Timing: reference and standby rates, fixed GPIO core ratio.
  localparam int CPRC_REF_KHZ   = 19200;
  localparam int CPRC_SB_KHZ    = 32;
  localparam int CPRC_SB_DIV    = CPRC_REF_KHZ / CPRC_SB_KHZ;
  localparam int CPRC_GCORE_DIV = 4;
  localparam int CPRC_SYS_DIV3  = 16;
  localparam logic [1:0] CPRC_OKAY   = 2'b00;
  localparam logic [1:0] CPRC_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    CPRC_NORMAL    = 2'b00,
    CPRC_SUSPEND   = 2'b01,
    CPRC_STANDBY   = 2'b11,
    CPRC_CORE_DOWN = 2'b10
  } cprc_mode_t;
endpackage : cprc_pkg

// file: hdl/cprc_top.sv
// Clock, power-mode and reset controller with AXI4-Lite registers.
// Assumes aclk is the PLL master clock; reference, 32 kHz and audio
// master clock arrive as synchronous one-cycle tick inputs.
`timescale 1ns/1ps
module cprc_top
  import cprc_pkg::*;
#(
  parameter int AW     = 8,
  parameter int SB_DIV = CPRC_SB_DIV
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  output logic [1:0]         s_axi_bresp,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  input  wire logic [AW-1:0] s_axi_araddr,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  input  wire logic          ref_tick,
  input  wire logic          ext_32k_tick,
  input  wire logic          i2s_mclk_tick,
  input  wire logic          pll_lock,
  input  wire logic          vdd_ok,
  input  wire logic [6:0]    wake_src,
  output logic               pll_en,
  output logic               cpu_clk_en,
  output logic               dma_clk_en,
  output logic               mmio_clk_en,
  output logic               gpio_fast_en,
  output logic               gpio_core_en,
  output logic               gpio_slow_en,
  output logic               i2s_clk_en,
  output logic               standby_tick,
  output logic               cpu_halt,
  output logic               ram_lowpower,
  output logic               ram_retention,
  output logic               core_power_off,
  output logic               io_freeze,
  output logic               lowpower_int,
  output logic               warm_boot,
  output logic               cpu_reset,
  output logic               device_reset,
  output logic               por_request
);
  typedef struct packed {
    cprc_mode_t  mode;
    logic [31:0] ctrl;
    logic [31:0] pll;
    logic [31:0] cpu;
    logic [31:0] gpf;
    logic [31:0] gps;
    logic [31:0] i2s;
    logic [31:0] wk;
    logic [6:0]  wk_evt;
    logic        pin_last;
    logic        cpu_rst;
    logic        dev_rst;
    logic        por;
    logic [3:0]  sys_cnt;
  } cprc_st_t;
  cprc_st_t q, d;

  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0]   wr_data;
  logic [3:0]    wr_strb;
  logic          wr_hit;
  logic [AW-1:0] rd_addr;
  logic [31:0]   rd_data;
  logic          rd_hit;
  logic          core_rst_n;
  logic          normal;
  logic          run;
  logic [3:0]    sys;
  logic          cpu_tk;
  logic          sb_ref;
  logic          sb_tk;
  logic          i2s_int;
  logic [6:0]    hits;
  logic          wake;

  // Merge a write into a register through byte strobes and a mask.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st,
                                        input logic [31:0] wm);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}} & wm;
    return (old & ~m) | (wd & m);
  endfunction : merge

  // Register read decode; unused offsets answer with an error.
  function automatic logic [31:0] rmux(input logic [7:0] a,
                                       input cprc_st_t s,
                                       input logic lk,
                                       input logic vd);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      CPRC_CTRL_OFS: r = s.ctrl;
      CPRC_PLL_OFS:  r = s.pll;
      CPRC_CPU_OFS:  r = s.cpu;
      CPRC_GPF_OFS:  r = s.gpf;
      CPRC_GPS_OFS:  r = s.gps;
      CPRC_I2S_OFS:  r = s.i2s;
      CPRC_MODE_OFS: r = {30'h0, s.mode};
      CPRC_WKEN_OFS: r = s.wk;
      CPRC_WKEV_OFS: r = {25'h0, s.wk_evt};
      CPRC_STAT_OFS: r = {27'h0, vd, |(s.wk_evt & s.wk[6:0]), lk,
                          s.mode};
      default:       r = 32'h0000_0000;
    endcase
    return r;
  endfunction : rmux

  cprc_axil #(
    .AW(AW)
  ) u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_hit        (wr_hit),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_hit        (rd_hit)
  );

  // Only aligned words up to the status register are mapped.
  assign wr_hit  = (wr_addr[1:0] == 2'b00) &&
                   (8'(wr_addr) <= CPRC_STAT_OFS);
  assign rd_hit  = (rd_addr[1:0] == 2'b00) &&
                   (8'(rd_addr) <= CPRC_STAT_OFS);
  assign rd_data = rmux(8'(rd_addr), q, pll_lock, vdd_ok);

  // A whole-device soft reset clears everything a hard reset does except the bus front end and the standby divider.
  assign core_rst_n = aresetn && !q.dev_rst;
  assign normal     = (q.mode == CPRC_NORMAL);
  assign run        = pll_en && pll_lock;

  // System clocks: master over 1, 2, 4 and 16, all phase aligned.
  assign sys[0] = run;
  assign sys[1] = run && q.sys_cnt[0];
  assign sys[2] = run && (q.sys_cnt[1:0] == 2'b11);
  assign sys[3] = run && (q.sys_cnt == 4'(CPRC_SYS_DIV3 - 1));

  // Processor clock halts outside normal mode; bus clocks follow it,
  // so all three stay mutually synchronous.
  cprc_div #(.W(4)) u_cpu (
    .aclk     (aclk),
    .rst_n    (core_rst_n),
    .tick_in  (sys[q.cpu[CPRC_SEL_LSB +: 2]]),
    .en       (normal),
    .div      (q.cpu[CPRC_CDIV_LSB +: 4]),
    .tick_out (cpu_tk)
  );
  assign cpu_clk_en = cpu_tk;

  // Bus clock dividers, each independent and 4 bits deep.
  cprc_div #(.W(4)) u_dma (
    .aclk     (aclk),
    .rst_n    (core_rst_n),
    .tick_in  (cpu_tk),
    .en       (q.cpu[CPRC_DMA_ON_B]),
    .div      (q.cpu[CPRC_DDIV_LSB +: 4]),
    .tick_out (dma_clk_en)
  );
  cprc_div #(.W(4)) u_mmio (
    .aclk     (aclk),
    .rst_n    (core_rst_n),
    .tick_in  (cpu_tk),
    .en       (q.cpu[CPRC_MMIO_ON_B]),
    .div      (q.cpu[CPRC_MDIV_LSB +: 4]),
    .tick_out (mmio_clk_en)
  );

  // GPIO fast clock and its fixed-ratio core clock.
  cprc_div #(.W(8)) u_gpf (
    .aclk     (aclk),
    .rst_n    (core_rst_n),
    .tick_in  (sys[q.gpf[CPRC_SEL_LSB +: 2]]),
    .en       (q.gpf[CPRC_PEN_B] && normal),
    .div      (q.gpf[CPRC_PDIV_LSB +: 8]),
    .tick_out (gpio_fast_en)
  );
  cprc_div #(.W(2)) u_gcore (
    .aclk     (aclk),
    .rst_n    (core_rst_n),
    .tick_in  (gpio_fast_en),
    .en       (1'b1),
    .div      (2'(CPRC_GCORE_DIV - 1)),
    .tick_out (gpio_core_en)
  );

  // GPIO slow clock straight from the reference.
  cprc_div #(.W(8)) u_gps (
    .aclk     (aclk),
    .rst_n    (core_rst_n),
    .tick_in  (ref_tick),
    .en       (q.gps[CPRC_PEN_B] && normal),
    .div      (q.gps[CPRC_PDIV_LSB +: 8]),
    .tick_out (gpio_slow_en)
  );

  // Audio internal clock; the external pin bypasses the divider.
  cprc_div #(.W(8)) u_i2s (
    .aclk     (aclk),
    .rst_n    (core_rst_n),
    .tick_in  (sys[q.i2s[CPRC_SEL_LSB +: 2]]),
    .en       (q.i2s[CPRC_PEN_B] && normal),
    .div      (q.i2s[CPRC_PDIV_LSB +: 8]),
    .tick_out (i2s_int)
  );
  assign i2s_clk_en = q.i2s[CPRC_PEN_B] && normal &&
    (q.i2s[CPRC_EXT_B] ? i2s_mclk_tick : i2s_int);

  // Standby clock from the reference; always on, so a device soft
  // reset does not disturb it.
  cprc_div #(.W(16)) u_sb (
    .aclk     (aclk),
    .rst_n    (aresetn),
    .tick_in  (ref_tick),
    .en       (1'b1),
    .div      (16'(SB_DIV - 1)),
    .tick_out (sb_ref)
  );
  assign sb_tk = q.pll[CPRC_SB_REF_B] ? sb_ref : ext_32k_tick;
  assign standby_tick = sb_tk;

  // Wakeup detection: level match on the level pin, toggle on the
  // edge pin, the remaining sources as active-high events.
  always_comb begin
    hits = wake_src;
    hits[CPRC_WK_LEVEL] = (wake_src[CPRC_WK_LEVEL] ==
                           q.wk[CPRC_WK_POL_B]);
    hits[CPRC_WK_EDGE]  = (wake_src[CPRC_WK_EDGE] != q.pin_last);
  end
  assign wake = |(q.wk_evt & q.wk[6:0]);

  // Register writes, power-mode sequencing and soft resets.
  always_comb begin
    d         = q;
    d.cpu_rst = 1'b0;
    d.dev_rst = 1'b0;
    d.por     = 1'b0;
    if (run) begin
      d.sys_cnt = q.sys_cnt + 4'h1;
    end
    if (wr_en && wr_hit) begin
      unique case (8'(wr_addr))
        CPRC_CTRL_OFS: begin
          d.ctrl    = merge(q.ctrl, wr_data, wr_strb, CPRC_CTRL_WM);
          d.cpu_rst = wr_strb[0] && wr_data[CPRC_CPU_RST_B];
          d.dev_rst = wr_strb[0] && wr_data[CPRC_DEV_RST_B];
        end
        CPRC_PLL_OFS: d.pll = merge(q.pll, wr_data, wr_strb, CPRC_PLL_WM);
        CPRC_CPU_OFS: d.cpu = merge(q.cpu, wr_data, wr_strb, CPRC_CPU_WM);
        CPRC_GPF_OFS: d.gpf = merge(q.gpf, wr_data, wr_strb, CPRC_PER_WM);
        CPRC_GPS_OFS: d.gps = merge(q.gps, wr_data, wr_strb, CPRC_PER_WM);
        CPRC_I2S_OFS: d.i2s = merge(q.i2s, wr_data, wr_strb, CPRC_I2S_WM);
        CPRC_WKEN_OFS: d.wk = merge(q.wk, wr_data, wr_strb, CPRC_WK_WM);
        CPRC_WKEV_OFS: begin
          if (wr_strb[0]) begin
            d.wk_evt = q.wk_evt & ~wr_data[6:0];
          end
        end
        CPRC_MODE_OFS: begin
          // Low-power entry is only taken from normal mode.
          if (normal && wr_strb[0]) begin
            if (wr_data[1:0] == CPRC_SUSPEND) begin
              d.mode = CPRC_SUSPEND;
            end else if (wr_data[1:0] == CPRC_STANDBY) begin
              d.mode = CPRC_STANDBY;
            end
          end
        end
        default: ;
      endcase
    end
    // Events are sampled on the standby clock; a new event wins over
    // a clear in the same cycle, so no wakeup can be lost.
    if (sb_tk) begin
      d.pin_last = wake_src[CPRC_WK_EDGE];
      d.wk_evt   = d.wk_evt | hits;
    end
    unique case (q.mode)
      CPRC_NORMAL: ;
      CPRC_SUSPEND: begin
        if (sb_tk && wake) begin
          d.mode = CPRC_NORMAL;
        end
      end
      CPRC_STANDBY: begin
        if (!vdd_ok) begin
          d.mode = CPRC_CORE_DOWN;
        end else if (sb_tk && wake) begin
          d.mode    = CPRC_NORMAL;
          d.cpu_rst = 1'b1;
        end
      end
      CPRC_CORE_DOWN: begin
        if (vdd_ok) begin
          d.dev_rst = 1'b1;
          d.por     = 1'b1;
        end
      end
    endcase
  end

  // State register; defaults on hard or whole-device reset.
  always_ff @(posedge aclk) begin
    if (!core_rst_n) begin
      q         <= '0;
      q.mode    <= CPRC_NORMAL;
      q.ctrl    <= CPRC_CTRL_RST;
      q.pll     <= CPRC_PLL_RST;
      q.cpu     <= CPRC_CPU_RST;
      q.gpf     <= CPRC_PER_RST;
      q.gps     <= CPRC_PER_RST;
      q.i2s     <= CPRC_PER_RST;
      q.wk      <= CPRC_WK_RST;
    end else begin
      q <= d;
    end
  end

  // Power-mode outputs. The PLL drops in every low-power mode, which
  // leaves only the standby clock running.
  assign pll_en         = q.pll[CPRC_PLL_EN_B] && normal;
  assign cpu_halt       = !normal;
  assign ram_lowpower   = (q.mode == CPRC_SUSPEND);
  assign ram_retention  = (q.mode == CPRC_STANDBY);
  assign core_power_off = (q.mode == CPRC_STANDBY) ||
                          (q.mode == CPRC_CORE_DOWN);
  assign io_freeze      = q.ctrl[CPRC_FREEZE_B] && !normal;
  assign lowpower_int   = q.ctrl[CPRC_LPINT_B] && !normal;
  assign warm_boot      = q.ctrl[CPRC_WARM_B];
  assign cpu_reset      = q.cpu_rst;
  assign device_reset   = q.dev_rst;
  assign por_request    = q.por;
endmodule : cprc_top

// file: testbench/cprc_checker.sv
// Port checks for the clock, power and reset controller.
// Assumes it is bound to cprc_top and watches only its ports.
`timescale 1ns/1ps
module cprc_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pll_en,
  input wire logic cpu_halt,
  input wire logic ram_retention,
  input wire logic cpu_reset,
  input wire logic device_reset
);
  // One clock domain, so clock and reset are declared once.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A reset request is a single-cycle pulse, never a level.
  sequence pulse_s(s); s ##1 !s; endsequence
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped unanswered");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid) else $error("rvalid dropped unanswered");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken during response");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_halt_pll_off: assert property (cpu_halt |-> !pll_en)
    else $error("pll on while halted");
  a_retain_pll_off: assert property (ram_retention |-> !pll_en)
    else $error("pll on in retention");
  a_pll_after_reset: assert property ($rose(aresetn) |-> pll_en)
    else $error("pll off after reset");
  a_cpu_rst_pulse: assert property (cpu_reset |-> pulse_s(cpu_reset))
    else $error("cpu reset too long");
  a_dev_rst_pulse: assert property (device_reset
    |-> pulse_s(device_reset)) else $error("device reset too long");
  a_dev_rst_pll: assert property (device_reset |-> ##[1:2] pll_en)
    else $error("pll not restored by device reset");
endmodule : cprc_checker

bind cprc_top cprc_checker cprc_checker_inst (.*);

// file: testbench/tb_clock_power_reset_control.sv
// Self-checking bench for the clock, power and reset controller.
// Assumes cprc_top with a short standby divider and a 100 MHz aclk.
`timescale 1ns/1ps
module tb_clock_power_reset_control import cprc_pkg::*; ;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, ref_tick, pll_en;
  logic ext_32k_tick, i2s_mclk_tick, pll_lock, vdd_ok, cpu_clk_en;
  logic dma_clk_en, mmio_clk_en, gpio_fast_en, gpio_core_en;
  logic gpio_slow_en, i2s_clk_en, standby_tick, cpu_halt, io_freeze;
  logic ram_lowpower, ram_retention, core_power_off, lowpower_int;
  logic warm_boot, cpu_reset, device_reset, por_request;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [6:0]  wake_src;
  logic [5:0]  tks;
  int          bad_count, comparisons, seed, n, pulses;
  cprc_top #(.SB_DIV(4)) cprc_top_inst (.*);
  // Every divided clock but gpio_slow_en and standby_tick in one vector, so one task can time any of them.
  assign tks = {i2s_clk_en, gpio_core_en, gpio_fast_en, mmio_clk_en,
                dma_clk_en, cpu_clk_en};
  // Free-running master clock.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Random reference ticks keep the standby divider irregular.
  always @(posedge aclk) ref_tick <= 1'($random(seed));
  // Counts every reset pulse the controller issues, spurious ones too.
  always @(posedge aclk)
    if (aresetn) pulses <= pulses + cpu_reset + device_reset + por_request;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Write with address and data offered together; each drops when taken.
  task automatic wr(logic [7:0] a, logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rc(logic [7:0] a, logic [31:0] e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    chk("read data", e, rv);
  endtask : rc
  // Skips one gap, since a new divider only lands at a period end.
  task automatic per(input int w, input string nm, input int e);
    int c;
    repeat (2) begin
      c = 0;
      do begin @(posedge aclk); c++; end while (tks[w] !== 1'b1 && c < 5000);
    end
    chk(nm, e, c);
  endtask : per
  function automatic int cdiv(logic [1:0] s, logic [3:0] d);
    return (s == 0 ? 1 : s == 1 ? 2 : s == 2 ? 4 : CPRC_SYS_DIV3) * (d + 1);
  endfunction : cdiv
  task end_sim;
    $display("counts %0d compared %0d wrong", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // Cuts a hang short well past the longest expected run.
  initial begin
    #1_000_000;
    bad_count++;
    end_sim;
  end
  // Main sequence: defaults, dividers, power modes, soft resets.
  initial begin
    {seed, bad_count, comparisons} = {32'd40, 64'd0};
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, ext_32k_tick, i2s_mclk_tick} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, wake_src} = '0;
    {s_axi_wstrb, pll_lock, vdd_ok} = 6'h3f;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc(CPRC_CTRL_OFS, CPRC_CTRL_RST);
    rc(CPRC_PLL_OFS, CPRC_PLL_RST);
    rc(CPRC_CPU_OFS, CPRC_CPU_RST);
    rc(8'h28, 32'h0);
    chk("unmapped resp", CPRC_SLVERR, rr);
    $display("test defaults done");
    for (n = 0; n < 4; n++) begin
      rv = (n == 0) ? 32'h3ff : $random(seed);
      rv[15:14] = 2'b11;
      rv[6] = rv[6] | (rv[9:6] == 4'h0);
      rv[13:10] = rv[9:6];
      wr(CPRC_CPU_OFS, rv & CPRC_CPU_WM);
      per(0, "cpu period", cdiv(rv[1:0], rv[5:2]));
      for (int w = 1; w < 3; w++) begin
        per(w, "bus period", cdiv(rv[1:0], rv[5:2]) * (rv[9:6] + 1));
      end
    end
    wr(CPRC_GPF_OFS, 32'h8009);
    wr(CPRC_I2S_OFS, 32'h8004);
    per(3, "gpio fast", cdiv(2'h1, 4'h2));
    per(4, "gpio core", cdiv(2'h1, 4'h2) * CPRC_GCORE_DIV);
    per(5, "i2s period", cdiv(2'h0, 4'h1));
    $display("test dividers done");
    wr(CPRC_PLL_OFS, 32'h3);
    wr(CPRC_WKEN_OFS, 32'h4);
    wr(CPRC_MODE_OFS, 32'h1);
    chk("suspend pins", 2'h3, {cpu_halt, ram_lowpower});
    wake_src <= 7'h08;
    repeat (60) @(posedge aclk);
    chk("pll unarmed", 1'b0, pll_en);
    wake_src <= 7'h0c;
    for (n = 0; n < 200 && pll_en !== 1'b1; n++) @(posedge aclk);
    rc(CPRC_MODE_OFS, 32'h0);
    wr(CPRC_CTRL_OFS, 32'h1c);
    // First standby is left by a wakeup, the second by losing supply.
    for (int k = 0; k < 2; k++) begin
      wake_src <= 7'h00;
      wr(CPRC_WKEV_OFS, 32'h7f);
      wr(CPRC_MODE_OFS, 32'h3);
      chk("standby pins", 5'h1f, {ram_retention, core_power_off,
          warm_boot, io_freeze, lowpower_int});
      if (k == 0) begin
        wake_src <= 7'h04;
        for (n = 0; n < 200 && pll_en !== 1'b1; n++) @(posedge aclk);
      end
    end
    chk("reset pulses", 1, pulses);
    vdd_ok <= 1'b0;
    repeat (20) @(posedge aclk);
    rc(CPRC_MODE_OFS, 32'h2);
    vdd_ok <= 1'b1;
    repeat (20) @(posedge aclk);
    rc(CPRC_PLL_OFS, CPRC_PLL_RST);
    chk("reset pulses", 3, pulses);
    $display("test power modes done");
    wr(CPRC_CPU_OFS, 32'h445);
    wr(CPRC_CTRL_OFS, 32'h1);
    rc(CPRC_CPU_OFS, 32'h445);
    wr(CPRC_CTRL_OFS, 32'h2);
    rc(CPRC_CPU_OFS, CPRC_CPU_RST);
    chk("reset pulses", 5, pulses);
    $display("test soft resets done");
    end_sim;
  end
endmodule : tb_clock_power_reset_control
